// File: include/lcdc_pkg.sv
/*
 Shared types, field codes and helpers for the segment display command decoder.
 Assumes a single device clock; all pin inputs are already synchronous to it.
*/
package lcdc_pkg;

   typedef enum logic [4:0]
   {
      ST_IDLE   = 5'h01,
      ST_RECV   = 5'h02,
      ST_STORE  = 5'h04,
      ST_ACK    = 5'h08,
      ST_IGNORE = 5'h10
   } lcdc_state_t;

   typedef enum logic [2:0]
   {
      PH_ADDR = 3'h1,
      PH_CMD  = 3'h2,
      PH_DATA = 3'h4
   } lcdc_phase_t;

   typedef struct packed
   {
      logic       power_saving_sel;
      logic       display_en;
      logic       bias_half;
      logic [1:0] drive_mode;
   } lcdc_cfg_t;

   typedef struct packed
   {
      logic       alt_bank_blink;
      logic [1:0] blink_rate_field;
   } lcdc_blink_t;

   // Drive mode codes
   localparam logic [1:0] MODE_STATIC = 2'h1;
   localparam logic [1:0] MODE_MUX2   = 2'h2;
   localparam logic [1:0] MODE_MUX3   = 2'h3;
   localparam logic [1:0] MODE_MUX4   = 2'h0;

   // Command byte layout
   localparam int         CONT_BIT  = 7;
   localparam int         PTR_BIT   = 6;
   localparam logic [1:0] OP_MODE   = 2'h2;
   localparam logic [3:0] OP_DEV    = 4'hc;
   localparam logic [4:0] OP_BANK   = 5'h1e;
   localparam logic [3:0] OP_BLINK  = 4'he;

   // Reset values
   localparam lcdc_cfg_t   CFG_RESET   = 5'h00;
   localparam lcdc_blink_t BLINK_RESET = 3'h0;

   // Byte and RAM geometry
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [2:0] BIT_LAST  = 3'h7;
   localparam int         RAM_DEPTH = 40;
   localparam logic [5:0] RAM_LAST  = 6'h27;
   localparam logic [1:0] BLINK_OFF = 2'h0;

   // Blink ratios for blink mode 1
   localparam int DIV_NORMAL_1 = 92160;
   localparam int DIV_SAVE_1   = 15360;

   // Three- and four-way modes have no alternate bank
   function automatic logic is_mux34(input logic [1:0] mode);
      is_mux34 = (mode == MODE_MUX3) || (mode == MODE_MUX4);
   endfunction

   // Last row offset written per RAM address
   function automatic logic [1:0] row_last(input logic [1:0] mode);
      case (mode)
         MODE_STATIC: row_last = 2'h0;
         MODE_MUX2:   row_last = 2'h1;
         MODE_MUX3:   row_last = 2'h2;
         default:     row_last = 2'h3;
      endcase
   endfunction

   // First row written, shifted to the upper bank when selected
   function automatic logic [1:0] row_base(input logic [1:0] mode, input logic bank);
      row_base = (!is_mux34(mode) && bank) ? 2'h2 : 2'h0;
   endfunction

endpackage

// File: hw/lcdc_decoder.sv
/*
 Write-only two-wire serial slave and command decoder for a segment display driver,
 with display RAM, bank selection and blink divider.
 Assumes scl/sda levels arrive synchronous to mclk_in and the wire level is resolved
 outside from the open-drain enables.
*/
`timescale 1ns/1ps
module lcdc_decoder
#(
   parameter logic [5:0] SLAVE_ADDR_HI    = 6'h15,  // Arbitrary upper address bits
   parameter int         BLINK_DIV_NORMAL = 92160,
   parameter int         BLINK_DIV_SAVE   = 15360,
   parameter int         DIV_W            = 19
)
(
   input  wire logic                 mclk_in,
   input  wire logic                 rstn_in,
   input  wire logic                 ce_in,
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   input  wire logic                 addr_lsb_strap_in,
   input  wire logic [2:0]           subaddr_pin_in,
   input  wire logic [5:0]           ram_rd_addr_in,
   output logic                      sda_out,
   output logic                      sda_oe_out,
   output logic                      scl_oe_out,
   output lcdc_pkg::lcdc_cfg_t       cfg_out,
   output lcdc_pkg::lcdc_blink_t     blink_out,
   output logic                      in_bank_out,
   output logic                      out_bank_eff_out,
   output logic                      blank_out,
   output logic [3:0]                ram_rd_data_out
);
   import lcdc_pkg::*;

   lcdc_state_t      state;
   lcdc_phase_t      phase;
   logic             scl_q;
   logic             sda_q;
   logic [7:0]       shreg;
   logic [3:0]       bit_cnt;
   logic [2:0]       wr_idx;
   logic             ack_pend;
   logic             out_bank;
   logic [5:0]       ptr;
   logic [2:0]       sub_cnt;
   logic [1:0]       row_off;
   logic [3:0]       ram [0:RAM_DEPTH-1];
   logic [DIV_W-1:0] blink_cnt;
   logic [DIV_W-1:0] next_limit;
   logic             blink_phase;
   logic             start_c;
   logic             stop_c;
   logic             scl_rise;
   logic             scl_fall;
   logic             addr_match;
   logic             sub_hit;
   logic             store_cmd;
   logic             wr_bit;
   logic             store_done;
   logic             alt_eff;

   ////////////////////////////////////////////////////////////////////////////////
   // Line events and decode terms
   assign start_c    = scl_q & scl_in & sda_q & ~sda_in;
   assign stop_c     = scl_q & scl_in & ~sda_q & sda_in;
   assign scl_rise   = ~scl_q & scl_in;
   assign scl_fall   = scl_q & ~scl_in;
   assign addr_match = (shreg[7:1] == {SLAVE_ADDR_HI, addr_lsb_strap_in}) && !shreg[0];
   assign sub_hit    = (sub_cnt == subaddr_pin_in);
   assign store_cmd  = (state == ST_STORE) && (phase == PH_CMD);
   assign wr_bit     = (state == ST_STORE) && (phase == PH_DATA);
   assign store_done = (state == ST_STORE) && ((phase != PH_DATA) || (wr_idx == BIT_LAST));
   assign alt_eff    = blink_out.alt_bank_blink && !is_mux34(cfg_out.drive_mode);

   ////////////////////////////////////////////////////////////////////////////////
   // Data bit steering terms
   logic             ack_drive;
   logic             bit_val;
   logic [1:0]       row_now;
   logic [DIV_W-1:0] half_limit;

   // Display bits leave the byte most significant first
   assign bit_val = shreg[BIT_LAST - wr_idx];
   // Row inside the RAM word, moved up when the upper input bank is chosen
   assign row_now = 2'(row_base(cfg_out.drive_mode, in_bank_out) + row_off);

   ////////////////////////////////////////////////////////////////////////////////
   // Line level history; idle level is high so reset makes no false edge
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else if (ce_in)
      begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transfer sequencer: address, command and data bytes with acknowledge
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         state     <= ST_IDLE;
         phase     <= PH_ADDR;
         shreg     <= 8'h00;
         bit_cnt   <= 4'h0;
         wr_idx    <= 3'h0;
         ack_pend  <= 1'b0;
         ack_drive <= 1'b0;
      end
      else if (ce_in)
      begin
         if (start_c)
         begin
            // A start always reopens the address phase
            state     <= ST_RECV;
            phase     <= PH_ADDR;
            bit_cnt   <= 4'h0;
            ack_pend  <= 1'b0;
            ack_drive <= 1'b0;
         end
         else if (stop_c)
         begin
            // A stop ends the transfer in every state
            state     <= ST_IDLE;
            phase     <= PH_ADDR;
            bit_cnt   <= 4'h0;
            ack_pend  <= 1'b0;
            ack_drive <= 1'b0;
         end
         else
         begin
            case (state)
               ST_IDLE:
               begin
                  bit_cnt <= 4'h0;
               end
               ST_RECV:
               begin
                  // Data is taken on the rising clock edge
                  if (scl_rise)
                  begin
                     shreg   <= {shreg[6:0], sda_in};
                     bit_cnt <= bit_cnt + 4'h1;
                     if (bit_cnt == BYTE_BITS - 4'h1)
                     begin
                        state  <= ST_STORE;
                        wr_idx <= 3'h0;
                     end
                  end
               end
               ST_STORE:
               begin
                  if (phase == PH_ADDR)
                  begin
                     if (addr_match)
                     begin
                        ack_pend <= 1'b1;
                        phase    <= PH_CMD;
                        state    <= ST_ACK;
                     end
                     else
                     begin
                        state <= ST_IGNORE;
                     end
                  end
                  else if (phase == PH_CMD)
                  begin
                     // Commands are answered whatever the subaddress
                     ack_pend <= 1'b1;
                     if (!shreg[CONT_BIT])
                        phase <= PH_DATA;
                     state <= ST_ACK;
                  end
                  else
                  begin
                     // Data answer follows the subaddress at byte start
                     if (wr_idx == 3'h0)
                        ack_pend <= sub_hit;
                     wr_idx <= wr_idx + 3'h1;
                     if (store_done)
                        state <= ST_ACK;
                  end
               end
               ST_ACK:
               begin
                  // Drive once the clock is low, release at the next fall
                  if (!ack_drive && !scl_in)
                  begin
                     ack_drive <= 1'b1;
                  end
                  else if (ack_drive && scl_fall)
                  begin
                     ack_drive <= 1'b0;
                     ack_pend  <= 1'b0;
                     bit_cnt   <= 4'h0;
                     state     <= ST_RECV;
                  end
               end
               ST_IGNORE:
               begin
                  // Foreign strap: wait silently for the stop
                  bit_cnt <= 4'h0;
               end
               default:
               begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Open-drain pin drives: acknowledge low, clock held low while busy
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         sda_out    <= 1'b1;
         sda_oe_out <= 1'b0;
         scl_oe_out <= 1'b0;
      end
      else if (ce_in)
      begin
         sda_out    <= !(ack_drive && ack_pend);
         sda_oe_out <= (state == ST_ACK) && ack_drive && ack_pend;
         scl_oe_out <= (state == ST_STORE) && !scl_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Command execution; every strap-matched device takes every command
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         cfg_out     <= CFG_RESET;
         blink_out   <= BLINK_RESET;
         in_bank_out <= 1'b0;
         out_bank    <= 1'b0;
      end
      else if (ce_in && store_cmd)
      begin
         if (shreg[6:5] == OP_MODE)
         begin
            // Power, enable, bias and drive mode in one go
            cfg_out <= lcdc_cfg_t'(shreg[4:0]);
         end
         else if (shreg[6:2] == OP_BANK)
         begin
            // No alternate bank exists in three- and four-way modes
            if (!is_mux34(cfg_out.drive_mode))
            begin
               in_bank_out <= shreg[1];
               out_bank    <= shreg[0];
            end
         end
         else if (shreg[6:3] == OP_BLINK)
         begin
            blink_out <= lcdc_blink_t'(shreg[2:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Data pointer, row offset and subaddress counter
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         ptr     <= 6'h00;
         sub_cnt <= 3'h0;
         row_off <= 2'h0;
      end
      else if (ce_in)
      begin
         if (store_cmd && !shreg[PTR_BIT])
         begin
            ptr     <= shreg[5:0];
            row_off <= 2'h0;
         end
         else if (store_cmd && (shreg[6:3] == OP_DEV))
         begin
            sub_cnt <= shreg[2:0];
            row_off <= 2'h0;
         end
         else if (wr_bit)
         begin
            // Advance per bit, so a cascade hand-over may fall mid-byte
            if (row_off == row_last(cfg_out.drive_mode))
            begin
               row_off <= 2'h0;
               if (ptr >= RAM_LAST)
               begin
                  ptr     <= 6'h00;
                  sub_cnt <= sub_cnt + 3'h1;
               end
               else
               begin
                  ptr <= ptr + 6'h1;
               end
            end
            else
            begin
               row_off <= row_off + 2'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Display RAM write, only for the selected subaddress
   always_ff @(posedge mclk_in)
   begin
      if (ce_in && wr_bit && sub_hit && (ptr <= RAM_LAST))
         ram[ptr][row_now] <= bit_val;
   end

   // Display RAM read port for the segment side
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
         ram_rd_data_out <= 4'h0;
      else if (ce_in)
         ram_rd_data_out <= (ram_rd_addr_in <= RAM_LAST) ? ram[ram_rd_addr_in] : 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Blink period: base ratio doubled per rate step
   always_comb
   begin
      next_limit = cfg_out.power_saving_sel ? DIV_W'(BLINK_DIV_SAVE)
                                            : DIV_W'(BLINK_DIV_NORMAL);
      next_limit = next_limit << (blink_out.blink_rate_field - 2'h1);
      half_limit = next_limit >> 1;
   end

   // Blink phase toggles every half period, so one cycle spans the ratio
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         blink_cnt   <= '0;
         blink_phase <= 1'b0;
      end
      else if (ce_in)
      begin
         if (blink_out.blink_rate_field == BLINK_OFF)
         begin
            blink_cnt   <= '0;
            blink_phase <= 1'b0;
         end
         else if (blink_cnt >= half_limit - DIV_W'(1))
         begin
            blink_cnt   <= '0;
            blink_phase <= ~blink_phase;
         end
         else
         begin
            blink_cnt <= blink_cnt + DIV_W'(1);
         end
      end
   end

   // Bank swap for alternate blinking, blanking for normal blinking
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         out_bank_eff_out <= 1'b0;
         blank_out        <= 1'b1;
      end
      else if (ce_in)
      begin
         out_bank_eff_out <= out_bank ^ (alt_eff && blink_phase);
         blank_out        <= !cfg_out.display_en ||
                             ((blink_out.blink_rate_field != BLINK_OFF) && !alt_eff && blink_phase);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks on the sequencer and the command effects
   sequence cmd_byte_s;
      ce_in && store_cmd && !start_c && !stop_c;
   endsequence

   sequence data_first_s;
      ce_in && wr_bit && (wr_idx == 3'h0) && !start_c && !stop_c;
   endsequence

   addr_ignore_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (ce_in && (state == ST_STORE) && (phase == PH_ADDR) && !addr_match && !start_c && !stop_c)
      |=> (state == ST_IGNORE))
      else $error("foreign address not ignored");

   ignore_quiet_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (state == ST_IGNORE) |-> !sda_oe_out)
      else $error("acknowledge while ignoring");

   cmd_ack_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      cmd_byte_s |=> (ack_pend && (state == ST_ACK)))
      else $error("command byte not acknowledged");

   data_ack_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      data_first_s ##0 !sub_hit |=> !ack_pend)
      else $error("foreign data byte acknowledged");

   ptr_load_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      cmd_byte_s ##0 !shreg[PTR_BIT] |=> (ptr == $past(shreg[5:0])))
      else $error("data pointer not loaded");

   bank_hold_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      cmd_byte_s ##0 ((shreg[6:2] == OP_BANK) && is_mux34(cfg_out.drive_mode))
      |=> $stable(in_bank_out))
      else $error("bank changed in three or four way mode");

   ptr_wrap_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (ce_in && wr_bit && !start_c && !stop_c && (ptr == RAM_LAST)
       && (row_off == row_last(cfg_out.drive_mode)))
      |=> ((ptr == 6'h00) && (sub_cnt == 3'($past(sub_cnt) + 3'h1))))
      else $error("pointer wrap wrong");

   clk_hold_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (ce_in && (state == ST_STORE) && !scl_in) |=> scl_oe_out)
      else $error("clock not held while busy");

   ack_low_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      sda_oe_out |-> !sda_out)
      else $error("data line driven high");
endmodule

// File: sim/lcdc_master.sv
/* Bus master model: start, bytes with acknowledge, stop.
 Assumes the bench resolves the open-drain wires. */
`timescale 1ns/1ps
module lcdc_master
(
   input  wire logic mclk_in,
   input  wire logic sda_in,
   input  wire logic scl_in,
   output logic      sda_out = 1'b1,
   output logic      scl_out = 1'b1
);
   // One clock pulse, waiting out a held-low clock
   task automatic pulse(input logic d, output logic q);
      repeat (8) @(negedge mclk_in);
      scl_out = 1'b0;
      repeat (8) @(negedge mclk_in);
      sda_out = d;
      repeat (8) @(negedge mclk_in);
      scl_out = 1'b1;
      for (int k = 0; k < 999 && !scl_in; k++)
         @(negedge mclk_in);
      repeat (8) @(negedge mclk_in);
      q = sda_in;
   endtask
   // Start when s is 0, stop when s is 1
   task automatic frame(input logic s);
      logic q;
      pulse(!s, q);
      sda_out = s;
   endtask
   // Byte out, then the acknowledge bit
   task automatic send(input logic [7:0] b, output logic a);
      logic q;
      for (int i = 7; i >= 0; i--)
         pulse(b[i], q);
      pulse(1'b1, q);
      a = !q;
   endtask
endmodule

// File: sim/test_lcdc_decoder.sv
/* Bench for the command decoder.
 Assumes lcdc_master as the bus master. */
`timescale 1ns/1ps
module test_lcdc_decoder;
   import lcdc_pkg::*;
   localparam logic [5:0] HI = 6'h2b;  // Arbitrary address bits
   logic mclk_in = 0;
   logic rstn_in = 0;
   logic ms, mc, so, soe, coe, ib, bk;
   logic ce = 1'b1;
   logic [5:0] ra = 6'h00;
   logic [3:0] rd;
   lcdc_cfg_t cfg;
   lcdc_blink_t bl;
   logic [7:0] m;
   int failures = 0;
   int check_count = 0;
   int seed = 32'h71a1;
   wire sda = ms & !(soe & !so);
   wire scl = mc & !coe;
   initial forever #2.5 mclk_in = ~mclk_in;
   lcdc_decoder #(.SLAVE_ADDR_HI(HI)) i_lcdc_decoder (.mclk_in, .rstn_in, .ce_in(ce),
      .scl_in(scl), .sda_in(sda), .addr_lsb_strap_in(1'b0), .subaddr_pin_in(3'h5),
      .ram_rd_addr_in(ra), .sda_out(so), .sda_oe_out(soe), .scl_oe_out(coe),
      .cfg_out(cfg), .blink_out(bl), .in_bank_out(ib), .out_bank_eff_out(),
      .blank_out(bk), .ram_rd_data_out(rd));
   lcdc_master i_lcdc_master (.mclk_in, .sda_in(sda), .scl_in(scl), .sda_out(ms), .scl_out(mc));
   // Compare and count
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // One transfer: address with strap bit s, then n bytes, acks compared to e
   task automatic tx(input logic s, input logic [47:0] b, input int n, input logic [6:0] e);
      logic [6:0] g;
      g = 7'h0;
      i_lcdc_master.frame(1'b0);
      i_lcdc_master.send({HI, s, 1'b0}, g[6]);
      for (int i = 0; i < n; i++)
         i_lcdc_master.send(b[47 - 8 * i -: 8], g[5 - i]);
      i_lcdc_master.frame(1'b1);
      chk("acks", {1'b0, e}, {1'b0, g});
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (20) @(negedge mclk_in);
      rstn_in = 1'b1;
      repeat (4)
      begin
         m = 8'($random(seed));
         m[7:5] = 3'h2;
         tx(1'b0, {m, 40'h0}, 1, 7'h60);
         chk("cfg", {3'h0, m[4:0]}, {3'h0, cfg});
      end
      tx(1'b1, {8'h41, 40'h0}, 1, 7'h00);
      chk("cfg kept", {3'h0, m[4:0]}, {3'h0, cfg});
      tx(1'b0, {32'he58375a5, 16'h0}, 4, 7'h7c);
      chk("blink", 8'h05, {5'h0, bl});
      tx(1'b0, {40'hc8e4265555, 8'h0}, 5, 7'h7a);
      tx(1'b0, {8'h7b, 40'h0}, 1, 7'h60);
      chk("bank mux", 8'h00, {7'h0, ib});
      tx(1'b0, {16'hc97b, 32'h0}, 2, 7'h70);
      chk("bank static", 8'h01, {7'h0, ib});
      chk("blank", 8'h00, {7'h0, bk});
      ra = 6'h00;
      repeat (3) @(negedge mclk_in);
      chk("ram 0", 8'h0a, {4'h0, rd});
      ra = 6'h01;
      repeat (3) @(negedge mclk_in);
      chk("ram 1", 8'h0a, {4'h0, rd});
      finish_test();
   end
   // Cut a hang short
   initial
   begin
      #200000;
      failures++;
      finish_test();
   end
endmodule
